// *** hdl/pfs_pkg.sv ***
`default_nettype none
package pfs_pkg;
   localparam int unsigned CLK_PER_CYCLE = 4;
   localparam logic [1:0]  PHASE_LAST    = 2'(CLK_PER_CYCLE - 1);
   localparam logic [15:0] PC_RESET      = 16'h0000;
   localparam logic [7:0]  SP_RESET      = 8'h00;
   localparam int unsigned PAGE_BITS     = 11;
   localparam logic [15:0] DISP_POS_MAX  = 16'h007f;
   localparam logic [15:0] DISP_NEG_MIN  = 16'hff80;

   // opcode encodings
   localparam logic [7:0]  OP_BIT_JUMP   = 8'h10;
   localparam logic [7:0]  OP_LONG_JUMP  = 8'h02;
   localparam logic [7:0]  OP_LONG_CALL  = 8'h03;
   localparam logic [7:0]  OP_SHORT_JUMP = 8'h04;
   localparam logic [7:0]  OP_SUB_EXIT   = 8'h05;
   localparam logic [7:0]  OP_INT_EXIT   = 8'h06;
   localparam logic [7:0]  OP_SLOW_MUL   = 8'h07;
   localparam logic [7:0]  OP_SLOW_DIV   = 8'h08;
   localparam logic [4:0]  OP_PAGE_LOW   = 5'h11;

   // byte lengths and instruction cycles minus one
   localparam logic [1:0]  LEN_ONE       = 2'h1;
   localparam logic [1:0]  LEN_TWO       = 2'h2;
   localparam logic [1:0]  LEN_THREE     = 2'h3;
   localparam logic [1:0]  CYC_ONE       = 2'h0;
   localparam logic [1:0]  CYC_TWO       = 2'h1;
   localparam logic [1:0]  CYC_FOUR      = 2'h3;

   typedef enum logic [3:0] {
      K_PLAIN,
      K_BIT,
      K_LONG,
      K_CALL,
      K_SHORT,
      K_PAGE,
      K_EXIT,
      K_IEXIT,
      K_SLOW
   } pfs_kind_t;

   function automatic pfs_kind_t pfs_decode(input logic [7:0] op);
      pfs_decode = K_PLAIN;
      if (op[4:0] == OP_PAGE_LOW)
         pfs_decode = K_PAGE;
      else if (op == OP_BIT_JUMP)
         pfs_decode = K_BIT;
      else if (op == OP_LONG_JUMP)
         pfs_decode = K_LONG;
      else if (op == OP_LONG_CALL)
         pfs_decode = K_CALL;
      else if (op == OP_SHORT_JUMP)
         pfs_decode = K_SHORT;
      else if (op == OP_SUB_EXIT)
         pfs_decode = K_EXIT;
      else if (op == OP_INT_EXIT)
         pfs_decode = K_IEXIT;
      else if (op == OP_SLOW_MUL || op == OP_SLOW_DIV)
         pfs_decode = K_SLOW;
   endfunction : pfs_decode

   function automatic logic [1:0] pfs_len(input pfs_kind_t k);
      unique case (k)
         K_BIT, K_LONG, K_CALL: pfs_len = LEN_THREE;
         K_SHORT, K_PAGE:       pfs_len = LEN_TWO;
         default:               pfs_len = LEN_ONE;
      endcase
   endfunction : pfs_len

   function automatic logic [1:0] pfs_cycles(input pfs_kind_t k);
      unique case (k)
         K_PLAIN: pfs_cycles = CYC_ONE;
         K_SLOW:  pfs_cycles = CYC_FOUR;
         default: pfs_cycles = CYC_TWO;
      endcase
   endfunction : pfs_cycles
endpackage : pfs_pkg
`default_nettype wire

// *** hdl/pfs_cycle_timer.sv ***
`timescale 1ns/100ps
`default_nettype none
module pfs_cycle_timer (
   input  wire logic       clk_sys,
   input  wire logic       rst_b,
   input  wire logic [1:0] cycles_m1,
   output logic      [1:0] phase,
   output logic            done
);
   logic [1:0] phase_q;
   logic [1:0] elapsed_q;

   assign phase = phase_q;
   assign done  = (phase_q == pfs_pkg::PHASE_LAST) && (elapsed_q == cycles_m1);

   // four clocks per instruction cycle, fixed
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
         phase_q <= 2'h0;
      else
         phase_q <= phase_q + 2'h1;
   end

   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
         elapsed_q <= 2'h0;
      else if (done)
         elapsed_q <= 2'h0;
      else if (phase_q == pfs_pkg::PHASE_LAST)
         elapsed_q <= elapsed_q + 2'h1;
   end
endmodule : pfs_cycle_timer
`default_nettype wire

// *** hdl/pfs_target_calc.sv ***
`timescale 1ns/100ps
`default_nettype none
module pfs_target_calc (
   input  wire logic [15:0] next_pc,
   input  wire logic [2:0]  page_hi,
   input  wire logic [7:0]  byte_now,
   input  wire logic [7:0]  byte_prev,
   output logic      [15:0] rel_target,
   output logic      [15:0] page_target,
   output logic      [15:0] long_target
);
   // signed displacement from the following instruction
   assign rel_target  = next_pc + {{8{byte_now[7]}}, byte_now};
   assign page_target = {next_pc[15:pfs_pkg::PAGE_BITS], page_hi, byte_now};
   assign long_target = {byte_prev, byte_now};
endmodule : pfs_target_calc
`default_nettype wire

// *** hdl/pfs_sequencer.sv ***
`timescale 1ns/100ps
`default_nettype none
module pfs_sequencer (
   input  wire logic        clk_sys,
   input  wire logic        rst_b,
   input  wire logic [7:0]  code_data,
   input  wire logic [7:0]  stack_rdata,
   input  wire logic        bit_value,
   input  wire logic        irq_req,
   input  wire logic        irq_enable,
   input  wire logic [15:0] irq_vector,
   output logic      [15:0] program_counter,
   output logic      [15:0] code_addr,
   output logic             code_rd,
   output logic      [7:0]  stack_addr,
   output logic      [7:0]  stack_wdata,
   output logic             stack_wr,
   output logic             stack_rd,
   output logic      [7:0]  bit_addr,
   output logic             bit_rd,
   output logic             irq_ack,
   output logic             in_service
);
   typedef enum logic [3:0] {
      S_FETCH,
      S_OP,
      S_B2,
      S_B3,
      S_IRQ,
      S_PUSH_LO,
      S_PUSH_HI,
      S_POP_HI,
      S_POP_LO,
      S_WAIT
   } pfs_state_t;

   pfs_state_t        state_q;
   pfs_pkg::pfs_kind_t kind_q;
   pfs_pkg::pfs_kind_t kind_d;
   logic [15:0]       pc_q;
   logic [15:0]       new_pc_q;
   logic [15:0]       push_val_q;
   logic [15:0]       next_pc;
   logic [15:0]       rel_target;
   logic [15:0]       page_target;
   logic [15:0]       long_target;
   logic [7:0]        op_q;
   logic [7:0]        byte2_q;
   logic [7:0]        hi_q;
   logic [7:0]        sp_q;
   logic [1:0]        cycles_m1;
   logic [1:0]        phase;
   logic              done;
   logic              irq_run_q;
   logic              in_service_q;
   logic              irq_take;
   logic [15:0]       code_addr_q;
   logic              code_rd_q;
   logic [7:0]        stack_addr_q;
   logic [7:0]        stack_wdata_q;
   logic              stack_wr_q;
   logic              stack_rd_q;
   logic [7:0]        bit_addr_q;
   logic              bit_rd_q;
   logic              irq_ack_q;

   assign kind_q   = pfs_pkg::pfs_decode(op_q);
   assign kind_d   = pfs_pkg::pfs_decode(code_data);
   assign next_pc  = pc_q + {14'h0000, pfs_pkg::pfs_len(kind_q)};
   assign irq_take = irq_req && irq_enable && !in_service_q;
   assign cycles_m1 = irq_run_q ? pfs_pkg::CYC_TWO
                                : pfs_pkg::pfs_cycles(kind_q);

   assign program_counter = pc_q;
   assign code_addr       = code_addr_q;
   assign code_rd         = code_rd_q;
   assign stack_addr      = stack_addr_q;
   assign stack_wdata     = stack_wdata_q;
   assign stack_wr        = stack_wr_q;
   assign stack_rd        = stack_rd_q;
   assign bit_addr        = bit_addr_q;
   assign bit_rd          = bit_rd_q;
   assign irq_ack         = irq_ack_q;
   assign in_service      = in_service_q;

   pfs_cycle_timer u_timer (
      .clk_sys   (clk_sys),
      .rst_b     (rst_b),
      .cycles_m1 (cycles_m1),
      .phase     (phase),
      .done      (done)
   );

   pfs_target_calc u_target (
      .next_pc     (next_pc),
      .page_hi     (op_q[7:5]),
      .byte_now    (code_data),
      .byte_prev   (byte2_q),
      .rel_target  (rel_target),
      .page_target (page_target),
      .long_target (long_target)
   );

   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
         state_q <= S_FETCH;
      else
      begin
         unique case (state_q)
            S_FETCH:   state_q <= S_OP;
            S_OP:
               if (kind_d == pfs_pkg::K_PLAIN || kind_d == pfs_pkg::K_SLOW)
                  state_q <= S_WAIT;
               else if (kind_d == pfs_pkg::K_EXIT ||
                        kind_d == pfs_pkg::K_IEXIT)
                  state_q <= S_POP_HI;
               else
                  state_q <= S_B2;
            S_B2:
               if (kind_q == pfs_pkg::K_SHORT || kind_q == pfs_pkg::K_PAGE)
                  state_q <= S_WAIT;
               else
                  state_q <= S_B3;
            S_B3:
               state_q <= (kind_q == pfs_pkg::K_CALL) ? S_PUSH_LO : S_WAIT;
            S_IRQ:     state_q <= S_PUSH_LO;
            S_PUSH_LO: state_q <= S_PUSH_HI;
            S_PUSH_HI: state_q <= S_WAIT;
            S_POP_HI:  state_q <= S_POP_LO;
            S_POP_LO:  state_q <= S_WAIT;
            S_WAIT:
               if (done)
                  state_q <= irq_take ? S_IRQ : S_FETCH;
         endcase
      end
   end

   // instruction bytes and target selection
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         op_q     <= 8'h00;
         byte2_q  <= 8'h00;
         new_pc_q <= pfs_pkg::PC_RESET;
      end
      else
      begin
         unique case (state_q)
            S_OP:
            begin
               op_q     <= code_data;
               new_pc_q <= pc_q + {14'h0000, pfs_pkg::pfs_len(kind_d)};
            end
            S_B2:
            begin
               byte2_q <= code_data;
               if (kind_q == pfs_pkg::K_SHORT)
                  new_pc_q <= rel_target;
               else if (kind_q == pfs_pkg::K_PAGE)
                  new_pc_q <= page_target;
            end
            S_B3:
               if (kind_q == pfs_pkg::K_LONG || kind_q == pfs_pkg::K_CALL)
                  new_pc_q <= long_target;
               else if (kind_q == pfs_pkg::K_BIT && bit_value)
                  new_pc_q <= rel_target;
            S_IRQ:     new_pc_q <= irq_vector;
            S_POP_LO:  new_pc_q <= {hi_q, stack_rdata};
            default:   new_pc_q <= new_pc_q;
         endcase
      end
   end

   // counter commits only at the end of the last instruction cycle
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
         pc_q <= pfs_pkg::PC_RESET;
      else if (done)
         pc_q <= new_pc_q;
   end

   // code fetch, one byte per clock
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         code_rd_q   <= 1'b0;
         code_addr_q <= pfs_pkg::PC_RESET;
      end
      else
      begin
         code_rd_q <= 1'b0;
         if (state_q == S_FETCH)
         begin
            code_rd_q   <= 1'b1;
            code_addr_q <= pc_q;
         end
         else if (state_q == S_OP && pfs_pkg::pfs_len(kind_d) != pfs_pkg::LEN_ONE)
         begin
            code_rd_q   <= 1'b1;
            code_addr_q <= pc_q + 16'h0001;
         end
         else if (state_q == S_B2 && pfs_pkg::pfs_len(kind_q) == pfs_pkg::LEN_THREE)
         begin
            code_rd_q   <= 1'b1;
            code_addr_q <= pc_q + 16'h0002;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         bit_rd_q   <= 1'b0;
         bit_addr_q <= 8'h00;
      end
      else
      begin
         bit_rd_q <= (state_q == S_B2) && (kind_q == pfs_pkg::K_BIT);
         if (state_q == S_B2 && kind_q == pfs_pkg::K_BIT)
            bit_addr_q <= code_data;
      end
   end

   // stack: push low then high, pop high then low
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         sp_q          <= pfs_pkg::SP_RESET;
         stack_wr_q    <= 1'b0;
         stack_rd_q    <= 1'b0;
         stack_addr_q  <= 8'h00;
         stack_wdata_q <= 8'h00;
         hi_q          <= 8'h00;
         push_val_q    <= pfs_pkg::PC_RESET;
      end
      else
      begin
         stack_wr_q <= 1'b0;
         stack_rd_q <= 1'b0;
         unique case (state_q)
            S_OP:
               if (kind_d == pfs_pkg::K_EXIT || kind_d == pfs_pkg::K_IEXIT)
               begin
                  stack_rd_q   <= 1'b1;
                  stack_addr_q <= sp_q;
               end
            S_B3:      push_val_q <= next_pc;
            S_IRQ:     push_val_q <= pc_q;
            S_PUSH_LO:
            begin
               stack_wr_q    <= 1'b1;
               stack_addr_q  <= sp_q + 8'h01;
               stack_wdata_q <= push_val_q[7:0];
               sp_q          <= sp_q + 8'h01;
            end
            S_PUSH_HI:
            begin
               stack_wr_q    <= 1'b1;
               stack_addr_q  <= sp_q + 8'h01;
               stack_wdata_q <= push_val_q[15:8];
               sp_q          <= sp_q + 8'h01;
            end
            S_POP_HI:
            begin
               hi_q         <= stack_rdata;
               stack_rd_q   <= 1'b1;
               stack_addr_q <= sp_q - 8'h01;
            end
            S_POP_LO:  sp_q <= sp_q - 8'h02;
            default:   sp_q <= sp_q;
         endcase
      end
   end

   // interrupt entry and in-service tracking
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         irq_run_q    <= 1'b0;
         irq_ack_q    <= 1'b0;
         in_service_q <= 1'b0;
      end
      else
      begin
         irq_ack_q <= (state_q == S_IRQ);
         if (state_q == S_IRQ)
         begin
            irq_run_q    <= 1'b1;
            in_service_q <= 1'b1;
         end
         else if (state_q == S_FETCH)
            irq_run_q <= 1'b0;
         if (state_q == S_POP_LO && kind_q == pfs_pkg::K_IEXIT)
            in_service_q <= 1'b0;
      end
   end

   sequence push_pair_s(logic [15:0] v);
      stack_wr_q && stack_wdata_q == v[7:0]
      ##1 stack_wr_q && stack_wdata_q == v[15:8];
   endsequence

   sequence three_fetch_s(logic [15:0] a);
      code_rd_q && code_addr_q == a + 16'h0001
      ##1 code_rd_q && code_addr_q == a + 16'h0002;
   endsequence

   cycle_four_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      done |-> phase == pfs_pkg::PHASE_LAST ##1 (!done)[*3])
      else $error("instruction end not on a four clock boundary");

   one_cycle_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (state_q == S_OP && kind_d == pfs_pkg::K_PLAIN) |-> !done ##2 done)
      else $error("plain instruction not one cycle");

   slow_cycle_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (state_q == S_OP && kind_d == pfs_pkg::K_SLOW) |-> ##14 done)
      else $error("slow instruction not four cycles");

   bit_taken_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (state_q == S_B3 && kind_q == pfs_pkg::K_BIT && bit_value)
      |=> new_pc_q == $past(rel_target))
      else $error("set bit did not branch");

   bit_fall_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (state_q == S_B3 && kind_q == pfs_pkg::K_BIT && !bit_value)
      |=> new_pc_q == $past(pc_q) + 16'h0003)
      else $error("clear bit did not fall through");

   short_range_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (state_q == S_B2 && kind_q == pfs_pkg::K_SHORT)
      |=> (new_pc_q - $past(next_pc) <= pfs_pkg::DISP_POS_MAX ||
           new_pc_q - $past(next_pc) >= pfs_pkg::DISP_NEG_MIN))
      else $error("relative target out of reach");

   long_fetch_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (state_q == S_OP && kind_d == pfs_pkg::K_LONG)
      |=> three_fetch_s($past(pc_q)))
      else $error("long jump not three bytes");

   long_target_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (state_q == S_B3 && kind_q == pfs_pkg::K_LONG)
      |=> new_pc_q == {$past(byte2_q), $past(code_data)})
      else $error("long jump target wrong");

   page_block_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (state_q == S_B2 && kind_q == pfs_pkg::K_PAGE)
      |=> new_pc_q[15:11] == $past(next_pc[15:11]))
      else $error("page jump left its block");

   call_push_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (state_q == S_B3 && kind_q == pfs_pkg::K_CALL)
      |-> ##2 push_pair_s($past(next_pc, 2)))
      else $error("call did not push return address");

   exit_resume_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (state_q == S_POP_LO) |=> new_pc_q == {$past(hi_q), $past(stack_rdata)})
      else $error("exit did not resume at popped address");

   irq_entry_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (state_q == S_WAIT && done && irq_take)
      |=> ##2 push_pair_s($past(new_pc_q, 3)) ##5 pc_q == $past(irq_vector, 8))
      else $error("interrupt entry wrong");

   seq_step_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (done && !irq_run_q && kind_q == pfs_pkg::K_PLAIN)
      |=> pc_q == $past(pc_q) + 16'h0001)
      else $error("plain instruction not sequential");
endmodule : pfs_sequencer
`default_nettype wire

// *** test/pfs_mem_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module pfs_mem_model (
   input  wire logic        clk_sys,
   input  wire logic [15:0] code_addr,
   input  wire logic        code_rd,
   output logic      [7:0]  code_data,
   input  wire logic [7:0]  stack_addr,
   input  wire logic [7:0]  stack_wdata,
   input  wire logic        stack_wr,
   input  wire logic        stack_rd,
   output logic      [7:0]  stack_rdata,
   input  wire logic [7:0]  bit_addr,
   input  wire logic        bit_rd,
   output logic             bit_value
);
   logic [7:0] code_mem [0:65535];
   logic [7:0] stack_mem [0:255];
   logic       bit_mem [0:255];
   logic [7:0] code_last_q;
   logic [7:0] stack_last_q;
   logic       bit_last_q;

   // unselected lines show the inverse of the last value, never a stale one
   assign code_data   = code_rd ? code_mem[code_addr] : ~code_last_q;
   assign stack_rdata = stack_rd ? stack_mem[stack_addr] : ~stack_last_q;
   assign bit_value   = bit_rd ? bit_mem[bit_addr] : ~bit_last_q;

   initial
   begin
      code_last_q  = 8'h00;
      stack_last_q = 8'h00;
      bit_last_q   = 1'b0;
      for (int i = 0; i < 65536; i++)
         code_mem[i] = 8'h00;
      for (int i = 0; i < 256; i++)
      begin
         stack_mem[i] = 8'h00;
         bit_mem[i]   = 1'b0;
      end
   end

   always @(posedge clk_sys)
   begin
      if (stack_wr)
         stack_mem[stack_addr] <= stack_wdata;
      code_last_q  <= code_data;
      stack_last_q <= stack_rdata;
      bit_last_q   <= bit_value;
   end
endmodule : pfs_mem_model
`default_nettype wire

// *** test/tb_program_flow_sequencer.sv ***
`timescale 1ns/100ps
`default_nettype none
module tb_program_flow_sequencer;
   logic        clk_sys = 1'b0;
   logic        rst_b = 1'b0;
   logic        irq_req = 1'b0;
   logic        irq_enable = 1'b0;
   logic [15:0] irq_vector = 16'h3000;
   logic [7:0]  code_data, stack_rdata, stack_addr, stack_wdata, bit_addr;
   logic [15:0] program_counter, code_addr;
   logic        bit_value, code_rd, stack_wr, stack_rd, bit_rd;
   logic        irq_ack, in_service;
   int          err_count = 0;
   int          tests_run = 0;
   int          ack_cnt = 0;

   always #2 clk_sys = ~clk_sys;

   pfs_sequencer u_dut (
      .clk_sys(clk_sys), .rst_b(rst_b), .code_data(code_data),
      .stack_rdata(stack_rdata), .bit_value(bit_value), .irq_req(irq_req),
      .irq_enable(irq_enable), .irq_vector(irq_vector),
      .program_counter(program_counter), .code_addr(code_addr),
      .code_rd(code_rd), .stack_addr(stack_addr), .stack_wdata(stack_wdata),
      .stack_wr(stack_wr), .stack_rd(stack_rd), .bit_addr(bit_addr),
      .bit_rd(bit_rd), .irq_ack(irq_ack), .in_service(in_service)
   );

   pfs_mem_model u_mem (
      .clk_sys(clk_sys), .code_addr(code_addr), .code_rd(code_rd),
      .code_data(code_data), .stack_addr(stack_addr),
      .stack_wdata(stack_wdata), .stack_wr(stack_wr), .stack_rd(stack_rd),
      .stack_rdata(stack_rdata), .bit_addr(bit_addr), .bit_rd(bit_rd),
      .bit_value(bit_value)
   );

   always @(posedge clk_sys)
      if (irq_ack === 1'b1)
         ack_cnt++;

   task automatic chk16(input string what, input logic [15:0] exp,
                        input logic [15:0] got);
      tests_run++;
      if (got !== exp)
      begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk16

   task automatic chk_n(input string what, input int exp, input int got);
      tests_run++;
      if (got != exp)
      begin
         err_count++;
         $display("[ERR] %s expected %0d seen %0d", what, exp, got);
      end
   endtask : chk_n

   task automatic put(input logic [15:0] a, input logic [7:0] b0,
                      input logic [7:0] b1, input logic [7:0] b2);
      u_mem.code_mem[a]         = b0;
      u_mem.code_mem[a + 16'h1] = b1;
      u_mem.code_mem[a + 16'h2] = b2;
   endtask : put

   // waits for the next counter change and measures its spacing
   task automatic step_pc(input logic [15:0] exp, input int clks);
      logic [15:0] prev;
      int          n;
      prev = program_counter;
      n = 0;
      while (program_counter === prev && n < 100)
      begin
         @(posedge clk_sys);
         #1;
         n++;
      end
      chk16("program_counter", exp, program_counter);
      if (clks > 0)
         chk_n("instruction clocks", clks, n);
   endtask : step_pc

   task automatic wait_pc(input logic [15:0] exp, input int max);
      int n;
      n = 0;
      while (program_counter !== exp && n < max)
      begin
         @(posedge clk_sys);
         #1;
         n++;
      end
      chk16("program_counter", exp, program_counter);
   endtask : wait_pc

   task automatic test_reset;
      repeat (3) @(posedge clk_sys);
      #1;
      chk16("program_counter", 16'h0000, program_counter);
      chk16("code_rd", 16'h0000, {15'h0, code_rd});
      @(posedge clk_sys);
      rst_b <= 1'b1;
      step_pc(16'h0001, 0);
      step_pc(16'h0002, 4);
   endtask : test_reset

   task automatic test_branches;
      step_pc(16'h0003, 16);
      step_pc(16'h0085, 8);
      step_pc(16'h0088, 8);
   endtask : test_branches

   task automatic test_jumps;
      step_pc(16'h000a, 8);
      step_pc(16'h1234, 8);
   endtask : test_jumps

   task automatic test_call_exit;
      step_pc(16'h2000, 8);
      chk16("pushed low", 16'h0037, {8'h0, u_mem.stack_mem[1]});
      chk16("pushed high", 16'h0012, {8'h0, u_mem.stack_mem[2]});
      step_pc(16'h2755, 8);
      step_pc(16'h1237, 8);
   endtask : test_call_exit

   // one clock of each measured span is spent driving the request
   task automatic test_irq;
      @(posedge clk_sys);
      irq_req <= 1'b1;
      step_pc(16'h1238, 16 - 1);
      chk_n("masked acks", 0, ack_cnt);
      @(posedge clk_sys);
      irq_enable <= 1'b1;
      wait_pc(16'h3000, 40);
      chk_n("acks", 1, ack_cnt);
      chk16("in_service", 16'h0001, {15'h0, in_service});
      chk16("resume low", 16'h0039, {8'h0, u_mem.stack_mem[1]});
      chk16("resume high", 16'h0012, {8'h0, u_mem.stack_mem[2]});
      @(posedge clk_sys);
      irq_req <= 1'b0;
      step_pc(16'h1239, 8 - 1);
      chk16("in_service", 16'h0000, {15'h0, in_service});
      chk_n("acks", 1, ack_cnt);
   endtask : test_irq

   task automatic test_done;
      $display("mismatches %0d checks %0d", err_count, tests_run);
      if (err_count == 0 && tests_run > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : test_done

   initial
   begin
      // plain, plain, slow, taken bit jump at the far forward edge
      put(16'h0000, 8'h00, 8'h00, 8'h07);
      put(16'h0003, 8'h10, 8'h45, 8'h7f);
      // bit clear, then short jump to the far backward edge
      put(16'h0085, 8'h10, 8'h46, 8'h80);
      put(16'h0088, 8'h04, 8'h80, 8'h00);
      put(16'h000a, 8'h02, 8'h12, 8'h34);
      put(16'h1234, 8'h03, 8'h20, 8'h00);
      // page jump with target bits 10:8 all ones
      put(16'h2000, 8'hf1, 8'h55, 8'h00);
      put(16'h2755, 8'h05, 8'h00, 8'h00);
      put(16'h1237, 8'h08, 8'h00, 8'h00);
      put(16'h1239, 8'h02, 8'h00, 8'h00);
      put(16'h3000, 8'h06, 8'h00, 8'h00);
      // neighbour bit set so a wrong bit address shows
      u_mem.bit_mem[8'h45] = 1'b1;
      u_mem.bit_mem[8'h47] = 1'b1;
      test_reset;
      test_branches;
      test_jumps;
      test_call_exit;
      test_irq;
      test_done;
   end

   initial
   begin
      #8000;
      err_count++;
      $display("[ERR] watchdog expected finish seen timeout");
      test_done;
   end
endmodule : tb_program_flow_sequencer
`default_nettype wire
